// file: bench/bidir_io_ports_b_c_test.sv
// Purpose: Self-checking bench for the port B and port C block.
// Assumes: Register map and latencies as the designer described them.
// Notes: Pin reads are compared only on pins with a defined level.

`timescale 1ns/1ps

module bidir_io_ports_b_c_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic sleep_mode = 0, porta_reset_combo = 0, counter_running = 0;
    logic pwm_wave = 0, wake_request;
    logic prescaler_tap_11 = 0, prescaler_tap_16 = 0, prescaler_tap_12 = 0;
    logic [3:0] pb_in, pb_out, pb_oe, pb_pullup_en, pb_pulldown_en;
    logic [3:0] pc_in, pc_out, pc_oe;
    logic [3:0] ext_pb = 0, ext_pb_en = 0, ext_pc = 0, ext_pc_en = 0;
    logic [3:0] eoe, eout, epu, epd, coe, cout, lvl, kn, clvl, ckn;
    logic [31:0] rnd = 32'd81136, got;
    logic [1:0] resp;
    int mreg[9];
    int fails = 0, samples_checked = 0, cyc = 0;

    always #5 aclk = ~aclk;

    gbc_ports gbc_ports_inst (.aclk, .aresetn, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .sleep_mode, .porta_reset_combo, .counter_running, .pwm_wave,
        .prescaler_tap_11, .prescaler_tap_16, .prescaler_tap_12,
        .wake_request, .pb_in, .pb_out, .pb_oe, .pb_pullup_en,
        .pb_pulldown_en, .pc_in, .pc_out, .pc_oe);

    gbc_board gbc_board_inst (.aclk, .pb_out, .pb_oe, .pb_pullup_en,
        .pb_pulldown_en, .pc_out, .pc_oe, .ext_pb, .ext_pb_en, .ext_pc,
        .ext_pc_en, .pb_in, .pc_in);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic report_and_stop;
        $display("Checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (mreg[i]) mreg[i] = 0;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // Write address and data are offered together; each drops when taken.
    task automatic wr(input logic [7:0] a, input logic [3:0] d,
                      input logic [3:0] st = 4'h1);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        s_axi_awvalid <= 1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1;
        s_axi_wdata <= {28'h0, d};
        s_axi_wstrb <= st;
        s_axi_bready <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        check(s_axi_bresp, (a <= 8'h20) ? 2'h0 : 2'h2);
        if (a <= 8'h20 && st[0])
            mreg[a >> 2] = d & ((a == 8'h18 || a == 8'h20) ? 1 : 15);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_arvalid <= 1;
        s_axi_araddr <= a;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        got = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask : rd

    task automatic rd_regs;
        for (int a = 4; a <= 32; a += 4) begin
            if (a == 20) continue;
            rd(a[7:0]);
            check(got, mreg[a >> 2]);
        end
    endtask : rd_regs

    ////////////////////////////////////////////////////////////////////////
    task automatic exp_pins;
        logic v, dir, od;
        for (int i = 0; i < 4; i++) begin
            v = mreg[0][i];
            if (i == 3 && mreg[8][0] && counter_running) v = pwm_wave;
            if (i == 2 && mreg[2][3]) v = prescaler_tap_11;
            if (i == 1 && mreg[2][2]) v = prescaler_tap_16;
            if (i == 0 && mreg[2][1]) v = prescaler_tap_12;
            dir = mreg[1][i];
            od = mreg[4][i];
            eoe[i] = dir & !(od & v);
            eout[i] = !od & v;
            epu[i] = od & (!dir | v);
            epd[i] = !mreg[3][i] & !od;
            kn[i] = eoe[i] | ext_pb_en[i] | epu[i] | epd[i];
            lvl[i] = eoe[i] ? eout[i] : ext_pb_en[i] ? ext_pb[i] : epu[i];
            v = mreg[5][i];
            od = mreg[7][2];
            coe[i] = mreg[6][0] & !sleep_mode & !(od & v);
            cout[i] = !od & v;
            ckn[i] = coe[i] | ext_pc_en[i];
            clvl[i] = coe[i] ? cout[i] : ext_pc[i];
        end
    endtask : exp_pins

    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        check(pb_oe | pc_oe, 4'h0);
        check(pb_pulldown_en, 4'hf);
        rd_regs();
        wr(8'h24, 4'h5);
        rd(8'h24);
        check({resp, got}, {2'h2, 32'h0});
        for (int n = 0; n < 40; n++) begin
            rnd = lfsr(rnd);
            wr(8'h00, rnd[3:0]);
            wr(8'h04, rnd[7:4]);
            wr(8'h08, rnd[11:8]);
            wr(8'h0c, rnd[15:12]);
            wr(8'h10, rnd[19:16]);
            wr(8'h14, rnd[23:20]);
            wr(8'h18, {3'h0, rnd[24]});
            wr(8'h1c, rnd[27:24]);
            wr(8'h20, {3'h0, rnd[28]});
            rnd = lfsr(rnd);
            wr(8'h04, rnd[31:28], 4'h0);
            {sleep_mode, porta_reset_combo, counter_running} <= rnd[2:0];
            {pwm_wave, prescaler_tap_11, prescaler_tap_16} <= rnd[5:3];
            prescaler_tap_12 <= rnd[6];
            {ext_pb, ext_pb_en, ext_pc, ext_pc_en} <= rnd[23:8];
            repeat (6) @(posedge aclk);
            exp_pins();
            check(pb_oe, eoe);
            check(pb_out, eout);
            check(pb_pullup_en, epu);
            check(pb_pulldown_en, epd);
            check(pc_oe, coe);
            check(pc_out & coe, cout & coe);
            check(wake_request, sleep_mode & porta_reset_combo & mreg[2][0]);
            rd(8'h00);
            check(got & kn, lvl & kn);
            rd(8'h14);
            check(got & ckn, clvl & ckn);
            rd_regs();
        end
        // Pull-ups are switched on only around one read of the pins.
        ext_pb_en <= 4'h0;
        wr(8'h04, 4'h0);
        wr(8'h10, 4'hf);
        repeat (4) @(posedge aclk);
        rd(8'h00);
        check(got, 4'hf);
        wr(8'h10, 4'h0);
        @(posedge aclk);
        check(pb_pullup_en, 4'h0);
        do_reset();
        check(pb_oe | pc_oe, 4'h0);
        rd_regs();
        report_and_stop();
    end
endmodule : bidir_io_ports_b_c_test

// file: bench/gbc_board.sv
// Purpose: Board side of the port B and port C pins.
// Assumes: Bench drives external levels only where it enables them.
// Notes: An undriven pin with no pull shows the inverse of its last level.

`timescale 1ns/1ps

module gbc_board (
    // Clock
    input wire logic aclk,
    // Device pin drive
    input wire logic [3:0] pb_out,
    input wire logic [3:0] pb_oe,
    input wire logic [3:0] pb_pullup_en,
    input wire logic [3:0] pb_pulldown_en,
    input wire logic [3:0] pc_out,
    input wire logic [3:0] pc_oe,
    // External drive
    input wire logic [3:0] ext_pb,
    input wire logic [3:0] ext_pb_en,
    input wire logic [3:0] ext_pc,
    input wire logic [3:0] ext_pc_en,
    // Pin levels
    output logic [3:0] pb_in,
    output logic [3:0] pc_in
);
    logic [3:0] last_pb = 4'h0;
    logic [3:0] last_pc = 4'h0;

    // A floating line must not look stable, so it toggles every cycle.
    always_ff @(posedge aclk) begin
        last_pb <= pb_in;
        last_pc <= pc_in;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pb_oe[i]) pb_in[i] = pb_out[i];
            else if (ext_pb_en[i]) pb_in[i] = ext_pb[i];
            else if (pb_pullup_en[i]) pb_in[i] = 1'b1;
            else if (pb_pulldown_en[i]) pb_in[i] = 1'b0;
            else pb_in[i] = ~last_pb[i];
            if (pc_oe[i]) pc_in[i] = pc_out[i];
            else if (ext_pc_en[i]) pc_in[i] = ext_pc[i];
            else pc_in[i] = ~last_pc[i];
        end
    end
endmodule : gbc_board

// file: src/gbc_pin_cell.sv
// Purpose: Drive and pull decision for one I/O pin.
// Assumes: Controls come from registers on the same clock.
// Notes: Purely combinational; the caller registers the result.

`timescale 1ns/1ps

module gbc_pin_cell (
    // Pin controls
    input gbc_pkg::gbc_pin_ctl_t ctl,
    // Pin drive
    output gbc_pkg::gbc_pin_drv_t drv
);

    always_comb begin
        // Open-drain releases the pin for a high level instead of driving.
        drv.oe = ctl.dir & ~ctl.hiz & ~(ctl.od & ctl.value);
        drv.out = ctl.od ? 1'b0 : ctl.value;
        // Pull-up needs open-drain and pull-down forbids it, so the two
        // can never meet on one pin.
        drv.pd = ctl.pd_opt & ~ctl.nopd & ~ctl.od;
        drv.pu = ctl.pu_opt & ctl.od & (~ctl.dir | ctl.value);
    end

endmodule : gbc_pin_cell

// file: src/gbc_pkg.sv
// Purpose: Shared constants and types for the port B and port C block.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes: Pin drive and pull controls are computed per pin by gbc_pin_cell.

package gbc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] OFF_PB_DATA = 8'h00;
    localparam logic [7:0] OFF_PB_DIR = 8'h04;
    localparam logic [7:0] OFF_PB_FSEL = 8'h08;
    localparam logic [7:0] OFF_PB_NOPD = 8'h0c;
    localparam logic [7:0] OFF_PB_OD = 8'h10;
    localparam logic [7:0] OFF_PC_DATA = 8'h14;
    localparam logic [7:0] OFF_PC_DIR = 8'h18;
    localparam logic [7:0] OFF_PC_OPT = 8'h1c;
    localparam logic [7:0] OFF_PRESC = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int FSEL_TAP11_BIT = 3;
    localparam int FSEL_TAP16_BIT = 2;
    localparam int FSEL_TAP12_BIT = 1;
    localparam int FSEL_WAKE_BIT = 0;
    localparam int PCOPT_NOPD_BIT = 3;
    localparam int PCOPT_OD_BIT = 2;
    localparam int PWM_PIN_BIT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [3:0] RST_PB_DATA = 4'h0;
    localparam logic [3:0] RST_PB_DIR = 4'h0;
    localparam logic [3:0] RST_PB_FSEL = 4'h0;
    localparam logic [3:0] RST_PB_NOPD = 4'h0;
    localparam logic [3:0] RST_PB_OD = 4'h0;
    localparam logic [3:0] RST_PC_DATA = 4'h0;
    localparam logic RST_PC_DIR = 1'b0;
    localparam logic [3:0] RST_PC_OPT = 4'h0;
    localparam logic RST_PRESC = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef struct packed {
        logic dir;
        logic value;
        logic od;
        logic nopd;
        logic pu_opt;
        logic pd_opt;
        logic hiz;
    } gbc_pin_ctl_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
        logic pd;
    } gbc_pin_drv_t;

    typedef struct packed {
        logic [3:0] pb_data;
        logic [3:0] pb_dir;
        logic [3:0] pb_fsel;
        logic [3:0] pb_nopd;
        logic [3:0] pb_od;
        logic [3:0] pc_data;
        logic pc_dir;
        logic [3:0] pc_opt;
        logic pwm_pin_enable;
    } gbc_regs_t;

endpackage : gbc_pkg

// file: src/gbc_ports.sv
// Purpose: Port B and port C general purpose I/O with AXI4-Lite registers.
// Assumes: Counter, prescaler taps and sleep state are on aclk.
// Notes: Pin outputs are registered, so they follow settings by one cycle.

`timescale 1ns/1ps

module gbc_ports #(
    parameter logic [3:0] PB_PULLUP_PRESENT = 4'hf,
    parameter logic [3:0] PB_PULLDOWN_PRESENT = 4'hf
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // Write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // Read address and data
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Device context
    input wire logic sleep_mode,
    input wire logic porta_reset_combo,
    input wire logic counter_running,
    input wire logic pwm_wave,
    input wire logic prescaler_tap_11,
    input wire logic prescaler_tap_16,
    input wire logic prescaler_tap_12,
    output logic wake_request,
    // Port B pins
    input wire logic [3:0] pb_in,
    output logic [3:0] pb_out,
    output logic [3:0] pb_oe,
    output logic [3:0] pb_pullup_en,
    output logic [3:0] pb_pulldown_en,
    // Port C pins
    input wire logic [3:0] pc_in,
    output logic [3:0] pc_out,
    output logic [3:0] pc_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode shared by the write and read paths.

    function automatic logic addr_known(input logic [7:0] addr);
        addr_known = (addr == gbc_pkg::OFF_PB_DATA) ||
                     (addr == gbc_pkg::OFF_PB_DIR) ||
                     (addr == gbc_pkg::OFF_PB_FSEL) ||
                     (addr == gbc_pkg::OFF_PB_NOPD) ||
                     (addr == gbc_pkg::OFF_PB_OD) ||
                     (addr == gbc_pkg::OFF_PC_DATA) ||
                     (addr == gbc_pkg::OFF_PC_DIR) ||
                     (addr == gbc_pkg::OFF_PC_OPT) ||
                     (addr == gbc_pkg::OFF_PRESC);
    endfunction : addr_known

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [3:0] pb_s1;
    logic [3:0] pb_s2;
    logic [3:0] pc_s1;
    logic [3:0] pc_s2;

    always_ff @(posedge aclk) begin
        pb_s1 <= pb_in;
        pb_s2 <= pb_s1;
        pc_s1 <= pc_in;
        pc_s2 <= pc_s1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bus slave and register file.

    gbc_pkg::gbc_regs_t regs;
    gbc_pkg::gbc_regs_t next_regs;
    logic aw_held;
    logic next_aw_held;
    logic [7:0] aw_addr;
    logic [7:0] next_aw_addr;
    logic w_held;
    logic next_w_held;
    logic [3:0] w_data;
    logic [3:0] next_w_data;
    logic w_lane0;
    logic next_w_lane0;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic [7:0] wr_addr;
    logic [3:0] wr_data;
    logic wr_lane0;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;

    always_comb begin
        next_regs = regs;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        wr_addr = aw_held ? aw_addr : s_axi_awaddr;
        wr_data = w_held ? w_data : s_axi_wdata[3:0];
        wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
        do_write = (aw_held | aw_hs) & (w_held | w_hs);
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_hs) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata[3:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_known(wr_addr) ? gbc_pkg::RESP_OKAY
                                             : gbc_pkg::RESP_SLVERR;
            if (wr_lane0) begin
                unique case (wr_addr)
                    gbc_pkg::OFF_PB_DATA: next_regs.pb_data = wr_data;
                    gbc_pkg::OFF_PB_DIR: next_regs.pb_dir = wr_data;
                    gbc_pkg::OFF_PB_FSEL: next_regs.pb_fsel = wr_data;
                    gbc_pkg::OFF_PB_NOPD: next_regs.pb_nopd = wr_data;
                    gbc_pkg::OFF_PB_OD: next_regs.pb_od = wr_data;
                    gbc_pkg::OFF_PC_DATA: next_regs.pc_data = wr_data;
                    gbc_pkg::OFF_PC_DIR: next_regs.pc_dir = wr_data[0];
                    gbc_pkg::OFF_PC_OPT: next_regs.pc_opt = wr_data;
                    gbc_pkg::OFF_PRESC: next_regs.pwm_pin_enable = wr_data[0];
                    default: next_regs = regs;
                endcase
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (ar_hs) begin
            next_rvalid = 1'b1;
            next_rdata = 32'h0;
            next_rresp = addr_known(s_axi_araddr) ? gbc_pkg::RESP_OKAY
                                                  : gbc_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                // Data addresses show the pins, never the stored value.
                gbc_pkg::OFF_PB_DATA: next_rdata[3:0] = pb_s2;
                gbc_pkg::OFF_PB_DIR: next_rdata[3:0] = regs.pb_dir;
                gbc_pkg::OFF_PB_FSEL: next_rdata[3:0] = regs.pb_fsel;
                gbc_pkg::OFF_PB_NOPD: next_rdata[3:0] = regs.pb_nopd;
                gbc_pkg::OFF_PB_OD: next_rdata[3:0] = regs.pb_od;
                gbc_pkg::OFF_PC_DATA: next_rdata[3:0] = pc_s2;
                gbc_pkg::OFF_PC_DIR: next_rdata[0] = regs.pc_dir;
                gbc_pkg::OFF_PC_OPT: next_rdata[3:0] = regs.pc_opt;
                gbc_pkg::OFF_PRESC: next_rdata[0] = regs.pwm_pin_enable;
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs.pb_data <= gbc_pkg::RST_PB_DATA;
            regs.pb_dir <= gbc_pkg::RST_PB_DIR;
            regs.pb_fsel <= gbc_pkg::RST_PB_FSEL;
            regs.pb_nopd <= gbc_pkg::RST_PB_NOPD;
            regs.pb_od <= gbc_pkg::RST_PB_OD;
            regs.pc_data <= gbc_pkg::RST_PC_DATA;
            regs.pc_dir <= gbc_pkg::RST_PC_DIR;
            regs.pc_opt <= gbc_pkg::RST_PC_OPT;
            regs.pwm_pin_enable <= gbc_pkg::RST_PRESC;
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 4'h0;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gbc_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= gbc_pkg::RESP_OKAY;
        end else begin
            regs <= next_regs;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive.

    logic [3:0] pb_value;
    gbc_pkg::gbc_pin_drv_t pb_drv [4];
    gbc_pkg::gbc_pin_drv_t pc_drv [4];
    logic [3:0] next_pb_out;
    logic [3:0] next_pb_oe;
    logic [3:0] next_pb_pu;
    logic [3:0] next_pb_pd;
    logic [3:0] next_pc_out;
    logic [3:0] next_pc_oe;
    logic next_wake;

    always_comb begin
        pb_value = regs.pb_data;
        if (regs.pwm_pin_enable && counter_running) begin
            pb_value[gbc_pkg::PWM_PIN_BIT] = pwm_wave;
        end
        if (regs.pb_fsel[gbc_pkg::FSEL_TAP11_BIT]) begin
            pb_value[2] = prescaler_tap_11;
        end
        if (regs.pb_fsel[gbc_pkg::FSEL_TAP16_BIT]) begin
            pb_value[1] = prescaler_tap_16;
        end
        if (regs.pb_fsel[gbc_pkg::FSEL_TAP12_BIT]) begin
            pb_value[0] = prescaler_tap_12;
        end
    end

    for (genvar i = 0; i < 4; i++) begin : g_pin
        gbc_pin_cell u_pb (
            .ctl('{dir: regs.pb_dir[i], value: pb_value[i],
                   od: regs.pb_od[i], nopd: regs.pb_nopd[i],
                   pu_opt: PB_PULLUP_PRESENT[i],
                   pd_opt: PB_PULLDOWN_PRESENT[i], hiz: 1'b0}),
            .drv(pb_drv[i])
        );
        // Port C pulls are handled outside this block.
        gbc_pin_cell u_pc (
            .ctl('{dir: regs.pc_dir, value: regs.pc_data[i],
                   od: regs.pc_opt[gbc_pkg::PCOPT_OD_BIT],
                   nopd: regs.pc_opt[gbc_pkg::PCOPT_NOPD_BIT],
                   pu_opt: 1'b0, pd_opt: 1'b0,
                   hiz: sleep_mode}),
            .drv(pc_drv[i])
        );
        assign next_pb_out[i] = pb_drv[i].out;
        assign next_pb_oe[i] = pb_drv[i].oe;
        assign next_pb_pu[i] = pb_drv[i].pu;
        assign next_pb_pd[i] = pb_drv[i].pd;
        assign next_pc_out[i] = pc_drv[i].out;
        assign next_pc_oe[i] = pc_drv[i].oe;
    end

    always_comb begin
        next_wake = sleep_mode & porta_reset_combo &
                    regs.pb_fsel[gbc_pkg::FSEL_WAKE_BIT];
    end

    // Registering the pins costs a cycle but keeps glitches off the pads.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pb_out <= 4'h0;
            pb_oe <= 4'h0;
            pb_pullup_en <= 4'h0;
            pb_pulldown_en <= PB_PULLDOWN_PRESENT;
            pc_out <= 4'h0;
            pc_oe <= 4'h0;
            wake_request <= 1'b0;
        end else begin
            pb_out <= next_pb_out;
            pb_oe <= next_pb_oe;
            pb_pullup_en <= next_pb_pu;
            pb_pulldown_en <= next_pb_pd;
            pc_out <= next_pc_out;
            pc_oe <= next_pc_oe;
            wake_request <= next_wake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_DIR_HIZ: assert property (
        (pb_oe & ~$past(regs.pb_dir)) == 4'h0)
        else $error("port B drives a pin set to input");

    AST_PB_READ_PIN: assert property (
        (ar_hs && s_axi_araddr == gbc_pkg::OFF_PB_DATA)
        |=> s_axi_rvalid && s_axi_rdata[3:0] == $past(pb_s2))
        else $error("port B data read did not return pin levels");

    AST_PD_RULE: assert property (
        pb_pulldown_en == $past(PB_PULLDOWN_PRESENT & ~regs.pb_nopd
                                & ~regs.pb_od))
        else $error("port B pull-down state is wrong");

    AST_PU_RULE: assert property (
        pb_pullup_en == $past(PB_PULLUP_PRESENT & regs.pb_od
                              & (~regs.pb_dir | pb_value)))
        else $error("port B pull-up state is wrong");

    AST_PULL_EXCL: assert property (
        (pb_pullup_en & pb_pulldown_en) == 4'h0)
        else $error("pull-up and pull-down active together");

    AST_OD_LOW_ONLY: assert property (
        (pb_oe & pb_out & $past(regs.pb_od)) == 4'h0)
        else $error("open-drain pin driven high");

    AST_PWM_ROUTE: assert property (
        (regs.pwm_pin_enable && counter_running && regs.pb_dir[3]
         && !regs.pb_od[3]) |=> pb_oe[3] && pb_out[3] == $past(pwm_wave))
        else $error("PWM not routed to port B pin 3");

    AST_TAP_ROUTE: assert property (
        (regs.pb_fsel[gbc_pkg::FSEL_TAP16_BIT] && regs.pb_dir[1]
         && !regs.pb_od[1]) |=> pb_out[1] == $past(prescaler_tap_16))
        else $error("tap 16 not routed to port B pin 1");

    AST_NO_WAKE: assert property (
        !regs.pb_fsel[gbc_pkg::FSEL_WAKE_BIT] |=> !wake_request)
        else $error("wake raised while disabled");

    AST_RESET_DIR: assert property (
        $rose(aresetn) |-> regs.pb_dir == 4'h0 && !regs.pc_dir
                           && regs.pb_od == 4'h0 && regs.pb_nopd == 4'h0)
        else $error("direction or options not cleared by reset");

    AST_PC_SLEEP: assert property (
        sleep_mode |=> pc_oe == 4'h0)
        else $error("port C driven during sleep");

    AST_PC_DIR: assert property (
        !$past(regs.pc_dir) |-> pc_oe == 4'h0)
        else $error("port C driven in input mode");

    COV_WRITE: cover property (do_write ##[1:4] s_axi_bvalid);
    COV_PWM: cover property (regs.pwm_pin_enable && counter_running
                             && regs.pb_dir[3]);
    COV_OD_PULLUP: cover property (pb_pullup_en != 4'h0);
    COV_WAKE: cover property (wake_request);

endmodule : gbc_ports
